// >>> pgg_chk.sv
`timescale 1ns/1ps
`include "pgg_consts.svh"

module pgg_chk
  import pgg_pkg::*;
(
  // Clock and reset
  input wire logic     ref_clk,
  input wire logic     rst,
  // Register port
  input wire pgg_req_t req,
  input wire pgg_rsp_t rsp,
  // Pins
  input wire logic     multiPinIn,
  input wire pgg_pin_t multiPin,
  input wire logic     auxPinIn,
  input wire pgg_pin_t auxPin,
  input wire logic     hwEnable
);
  logic [7:0] mCopy_reg;
  logic [7:0] aCopy_reg;
  logic       gpio;
  logic       pat;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Own copies of mode and aux; a latch write leaves mode alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mCopy_reg <= `PGG_RST_MODE;
      aCopy_reg <= `PGG_RST_AUX;
    end else if (req.wr) begin
      if (req.addr == `PGG_ADDR_MODE && req.wdata[5:3] != `PGG_DUTY_LATCH) mCopy_reg <= req.wdata;
      if (req.addr == `PGG_ADDR_AUX) aCopy_reg <= req.wdata;
    end
  end
  assign gpio = mCopy_reg[0] && mCopy_reg[5:3] == `PGG_DUTY_GPIO;
  assign pat  = mCopy_reg[0] && mCopy_reg[5:3] != `PGG_DUTY_GPIO;
  ////////////////////////////////////////////////////////////
  property p_hardware_enable_input_free; !mCopy_reg[0] |=> !multiPin.oe; endproperty
  a_hardware_enable_input_free: assert property (p_hardware_enable_input_free) else $error("pin driven in enable mode");
  property p_hardware_enable_input_low; (!mCopy_reg[0] && !multiPinIn) [*8] |-> !hwEnable; endproperty
  a_hardware_enable_input_low: assert property (p_hardware_enable_input_low) else $error("enable ignores pin");
  property p_gpio_out; gpio && !mCopy_reg[1] |=> multiPin == {$past(mCopy_reg[2]), 1'b1}; endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("pin output wrong");
  property p_gpio_in; gpio && mCopy_reg[1] |=> !multiPin.oe; endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("input pin driven");
  property p_pat_sink; pat |=> !multiPin.out; endproperty
  a_pat_sink: assert property (p_pat_sink) else $error("pattern drives high");
  property p_aux_in; !aCopy_reg[0] |=> !auxPin.oe; endproperty
  a_aux_in: assert property (p_aux_in) else $error("aux input driven");
  property p_aux_out; aCopy_reg[0] |=> auxPin == {$past(aCopy_reg[1]), 1'b1}; endproperty
  a_aux_out: assert property (p_aux_out) else $error("aux output wrong");
  property p_aux_read; req.rd && req.addr == `PGG_ADDR_AUX |=> rsp.valid &&
    rsp.data[7:2] == 6'h3f && rsp.data[0] == $past(aCopy_reg[0]); endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux read wrong");
  property p_mode_keep; req.rd && req.addr == `PGG_ADDR_MODE |=> rsp.valid &&
    rsp.data[7:3] == $past(mCopy_reg[7:3]) && rsp.data[1:0] == $past(mCopy_reg[1:0]); endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode read wrong");
  c_pattern: cover property (pat ##1 multiPin.oe);
  c_aux_out: cover property (aCopy_reg[0] && auxPin.out);
  c_hardware_enable_input_low: cover property (!mCopy_reg[0] && !hwEnable);
endmodule

bind pgg_pattern_generator_gpio pgg_chk i_pgg_chk (.ref_clk(ref_clk), .rst(rst), .req(req),
  .rsp(rsp), .multiPinIn(multiPinIn), .multiPin(multiPin), .auxPinIn(auxPinIn),
  .auxPin(auxPin), .hwEnable(hwEnable));

// >>> pgg_consts.svh
// Functional notes
// - Aux pin direction bit 0 low: pin is input, level read in bit 1.
// - Aux pin direction bit 0 high: pin driven as output from bit 1.
// - Four 8-bit data registers hold a 32-bit pattern shifted out in pattern mode.
// - Pattern goes out LSB first: byte0 bit 0 first, byte3 bit 7 last.
// - Pattern bit 1 pulls the pin low; bit 0 leaves it open drain.
// - At half duty a dead interval of one pattern period follows each pattern.
// - Period code 01 gives 26 ms per bit; duty code 010 gives half duty.
// - Writing 111 into mode bits 5:3 latches data bytes into the shift register and restarts the pattern; mode is kept.
// - Period codes 00/01/10/11 give 1.6us/26ms/52ms/105ms; pattern is 32 bits.
// - Duty 010/011/100/101/110 gives 1/2,1/3,1/4,1/6; dead = 32*bit*(1/duty-1).
// - Mode bit 0 low: pin is active-high hardware enable input.
// - Mode bit 0 high, duty 000: bit 1 picks direction, data in bit 2.
`ifndef PGG_CONSTS_SVH
`define PGG_CONSTS_SVH

// Register offsets
`define PGG_ADDR_MODE   8'h80
`define PGG_ADDR_AUX    8'h81
`define PGG_ADDR_DATA0  8'h90
`define PGG_ADDR_DATA1  8'h91
`define PGG_ADDR_DATA2  8'h92
`define PGG_ADDR_DATA3  8'h93

// Reset values
`define PGG_RST_MODE    8'h01
`define PGG_RST_AUX     8'hfc
`define PGG_RST_DATA    8'h00

// Field positions
`define PGG_MODE_EN_BIT    0
`define PGG_MODE_DIR_BIT   1
`define PGG_MODE_DATA_BIT  2
`define PGG_MODE_DUTY_LO   3
`define PGG_MODE_DUTY_HI   5
`define PGG_MODE_PER_LO    6
`define PGG_MODE_PER_HI    7
`define PGG_AUX_DIR_BIT    0
`define PGG_AUX_DATA_BIT   1

// Duty codes
`define PGG_DUTY_GPIO   3'h0
`define PGG_DUTY_FULL   3'h1
`define PGG_DUTY_HALF   3'h2
`define PGG_DUTY_THIRD  3'h3
`define PGG_DUTY_QUART  3'h4
`define PGG_DUTY_SIXA   3'h5
`define PGG_DUTY_SIXB   3'h6
`define PGG_DUTY_LATCH  3'h7

// Timing, clock period and bit periods in ns
`define PGG_CLK_NS      40
`define PGG_BIT0_NS     1600
`define PGG_BIT1_NS     26000000
`define PGG_BIT2_NS     52000000
`define PGG_BIT3_NS     105000000
`define PGG_BIT0_CYC    ((`PGG_BIT0_NS + `PGG_CLK_NS - 1) / `PGG_CLK_NS)
`define PGG_BIT1_CYC    ((`PGG_BIT1_NS + `PGG_CLK_NS - 1) / `PGG_CLK_NS)
`define PGG_BIT2_CYC    ((`PGG_BIT2_NS + `PGG_CLK_NS - 1) / `PGG_CLK_NS)
`define PGG_BIT3_CYC    ((`PGG_BIT3_NS + `PGG_CLK_NS - 1) / `PGG_CLK_NS)
`define PGG_PAT_BITS    32

`endif

// >>> pgg_led_model.sv
`timescale 1ns/1ps

module pgg_led_model
  import pgg_pkg::*;
(
  // Device side
  input  wire pgg_pin_t multiPin,
  input  wire pgg_pin_t auxPin,
  // Far levels while released
  input  wire logic     multiExt,
  input  wire logic     auxExt,
  // Sensed levels
  output logic          multiPinIn,
  output logic          auxPinIn
);
  // Released pin shows the far level, never the last driven one
  assign multiPinIn = multiPin.oe ? multiPin.out : multiExt;
  assign auxPinIn   = auxPin.oe ? auxPin.out : auxExt;
endmodule

// >>> pgg_pattern_generator_gpio.sv
`timescale 1ns/1ps
`include "pgg_consts.svh"

module pgg_pattern_generator_gpio
  import pgg_pkg::*;
#(
  parameter int unsigned BIT1_CYC = `PGG_BIT1_CYC,
  parameter int unsigned BIT2_CYC = `PGG_BIT2_CYC,
  parameter int unsigned BIT3_CYC = `PGG_BIT3_CYC
) (
  // Clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // Register access
  input  wire pgg_req_t req,
  output pgg_rsp_t      rsp,
  // Multi-function pin
  input  wire logic     multiPinIn,
  output pgg_pin_t      multiPin,
  // Aux pin
  input  wire logic     auxPinIn,
  output pgg_pin_t      auxPin,
  // Enable to the rest of the chip
  output logic          hwEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] bitCycles(input logic [1:0] code);
    case (code)
      2'h0:    bitCycles = 32'(`PGG_BIT0_CYC);
      2'h1:    bitCycles = 32'(BIT1_CYC);
      2'h2:    bitCycles = 32'(BIT2_CYC);
      default: bitCycles = 32'(BIT3_CYC);
    endcase
  endfunction

  // Dead time counted in whole pattern periods
  function automatic logic [2:0] deadPatterns(input logic [2:0] duty);
    case (duty)
      `PGG_DUTY_HALF:  deadPatterns = 3'h1;
      `PGG_DUTY_THIRD: deadPatterns = 3'h2;
      `PGG_DUTY_QUART: deadPatterns = 3'h3;
      `PGG_DUTY_SIXA:  deadPatterns = 3'h5;
      `PGG_DUTY_SIXB:  deadPatterns = 3'h5;
      default:         deadPatterns = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  pgg_state_t s_reg;
  pgg_state_t s_next;

  logic [2:0]  duty;
  logic        patOn;
  logic [31:0] period;

  assign duty   = s_reg.modeReg[`PGG_MODE_DUTY_HI:`PGG_MODE_DUTY_LO];
  assign patOn  = s_reg.modeReg[`PGG_MODE_EN_BIT] && (duty != `PGG_DUTY_GPIO);
  assign period = bitCycles(s_reg.modeReg[`PGG_MODE_PER_HI:`PGG_MODE_PER_LO]);

  always_comb begin
    s_next = s_reg;
    s_next.rsp.valid = 1'b0;

    // Pin synchronisers, a change counts once stages two and three agree
    s_next.mSync = {s_reg.mSync[1:0], multiPinIn};
    s_next.aSync = {s_reg.aSync[1:0], auxPinIn};
    if (s_reg.mSync[1] == s_reg.mSync[2]) begin
      s_next.mLevel = s_reg.mSync[2];
    end
    if (s_reg.aSync[1] == s_reg.aSync[2]) begin
      s_next.aLevel = s_reg.aSync[2];
    end

    // Pattern engine, bit rate from the local clock
    if (!patOn) begin
      s_next.preCnt   = 32'h0000_0000;
      s_next.bitIdx   = 5'h00;
      s_next.deadLeft = 3'h0;
      s_next.phase    = PGG_ACTIVE;
    end else if (s_reg.preCnt >= period - 32'h0000_0001) begin
      s_next.preCnt = 32'h0000_0000;
      if (s_reg.bitIdx == 5'(`PGG_PAT_BITS - 1)) begin
        s_next.bitIdx = 5'h00;
        case (s_reg.phase)
          PGG_ACTIVE: begin
            s_next.deadLeft = deadPatterns(duty);
            if (deadPatterns(duty) != 3'h0) begin
              s_next.phase = PGG_DEAD;
            end
          end
          PGG_DEAD: begin
            s_next.deadLeft = s_reg.deadLeft - 3'h1;
            if (s_reg.deadLeft == 3'h1) begin
              s_next.phase = PGG_ACTIVE;
            end
          end
          default: s_next.phase = PGG_ACTIVE;
        endcase
      end else begin
        s_next.bitIdx = s_reg.bitIdx + 5'h01;
      end
    end else begin
      s_next.preCnt = s_reg.preCnt + 32'h0000_0001;
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        `PGG_ADDR_MODE: begin
          if (req.wdata[`PGG_MODE_DUTY_HI:`PGG_MODE_DUTY_LO] == `PGG_DUTY_LATCH) begin
            // Latch only, other bits of this write are dropped
            s_next.shiftReg = s_reg.dataReg;
            s_next.preCnt   = 32'h0000_0000;
            s_next.bitIdx   = 5'h00;
            s_next.deadLeft = 3'h0;
            s_next.phase    = PGG_ACTIVE;
          end else begin
            s_next.modeReg = req.wdata;
          end
        end
        `PGG_ADDR_AUX: begin
          // Upper bits are fixed ones
          s_next.auxReg = {6'h3f, req.wdata[1:0]};
        end
        `PGG_ADDR_DATA0: s_next.dataReg[7:0]   = req.wdata;
        `PGG_ADDR_DATA1: s_next.dataReg[15:8]  = req.wdata;
        `PGG_ADDR_DATA2: s_next.dataReg[23:16] = req.wdata;
        `PGG_ADDR_DATA3: s_next.dataReg[31:24] = req.wdata;
        default: ;
      endcase
    end

    // Register reads, input levels shown where the direction bit selects input
    if (req.rd) begin
      s_next.rsp.valid = 1'b1;
      case (req.addr)
        `PGG_ADDR_MODE: begin
          s_next.rsp.data = s_reg.modeReg;
          if (s_reg.modeReg[`PGG_MODE_DIR_BIT]) begin
            s_next.rsp.data[`PGG_MODE_DATA_BIT] = s_reg.mLevel;
          end
        end
        `PGG_ADDR_AUX: begin
          s_next.rsp.data = s_reg.auxReg;
          if (!s_reg.auxReg[`PGG_AUX_DIR_BIT]) begin
            s_next.rsp.data[`PGG_AUX_DATA_BIT] = s_reg.aLevel;
          end
        end
        `PGG_ADDR_DATA0: s_next.rsp.data = s_reg.dataReg[7:0];
        `PGG_ADDR_DATA1: s_next.rsp.data = s_reg.dataReg[15:8];
        `PGG_ADDR_DATA2: s_next.rsp.data = s_reg.dataReg[23:16];
        `PGG_ADDR_DATA3: s_next.rsp.data = s_reg.dataReg[31:24];
        default:         s_next.rsp.data = 8'h00;
      endcase
    end

    // Multi-function pin drive
    if (!s_reg.modeReg[`PGG_MODE_EN_BIT]) begin
      s_next.multiPin = '{out: 1'b0, oe: 1'b0};
      s_next.hwEnable = s_reg.mLevel;
    end else if (patOn) begin
      // Only ever sinks, so a stuck one cannot fight an external pull-up
      s_next.multiPin.out = 1'b0;
      s_next.multiPin.oe  = (s_reg.phase == PGG_ACTIVE)
                            && s_reg.shiftReg[s_reg.bitIdx];
      s_next.hwEnable     = 1'b1;
    end else begin
      s_next.multiPin.out = s_reg.modeReg[`PGG_MODE_DATA_BIT];
      s_next.multiPin.oe  = !s_reg.modeReg[`PGG_MODE_DIR_BIT];
      s_next.hwEnable     = 1'b1;
    end

    // Aux pin drive
    s_next.auxPin.oe  = s_reg.auxReg[`PGG_AUX_DIR_BIT];
    s_next.auxPin.out = s_reg.auxReg[`PGG_AUX_DATA_BIT];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.modeReg  <= `PGG_RST_MODE;
      s_reg.auxReg   <= `PGG_RST_AUX;
      s_reg.dataReg  <= {4{`PGG_RST_DATA}};
      s_reg.phase    <= PGG_ACTIVE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rsp      = s_reg.rsp;
  assign multiPin = s_reg.multiPin;
  assign auxPin   = s_reg.auxPin;
  assign hwEnable = s_reg.hwEnable;

endmodule

// >>> pgg_pkg.sv
package pgg_pkg;

  // Register access request from the host serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgg_req_t;

  // Open-drain or push-pull pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } pgg_pin_t;

  // Register read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pgg_rsp_t;

  typedef enum logic {
    PGG_ACTIVE,
    PGG_DEAD
  } pgg_phase_t;

  typedef struct packed {
    logic [7:0]  modeReg;
    logic [7:0]  auxReg;
    logic [31:0] dataReg;
    logic [31:0] shiftReg;
    logic [31:0] preCnt;
    logic [4:0]  bitIdx;
    logic [2:0]  deadLeft;
    pgg_phase_t  phase;
    logic [2:0]  mSync;
    logic        mLevel;
    logic [2:0]  aSync;
    logic        aLevel;
    pgg_pin_t    multiPin;
    pgg_pin_t    auxPin;
    logic        hwEnable;
    pgg_rsp_t    rsp;
  } pgg_state_t;

endpackage

// >>> testbench.sv
`timescale 1ns/1ps
`include "pgg_consts.svh"

module testbench
  import pgg_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  pgg_req_t    req = '0;
  pgg_rsp_t    rsp;
  pgg_pin_t    multiPin;
  pgg_pin_t    auxPin;
  logic        multiPinIn;
  logic        auxPinIn;
  logic        hwEnable;
  logic        multiExt = 1'b1;
  logic        auxExt = 1'b0;
  int          error_cnt = 0;
  int          n_checks = 0;
  // End bytes differ so a reversed order shows
  logic [31:0] pat = 32'h810f_ac35;
  logic [7:0]  modeTab [9] = '{8'h11, 8'h19, 8'h21, 8'h29, 8'h31, 8'h51, 8'h49, 8'h89, 8'hc9};
  int          perTab [9] = '{40, 40, 40, 40, 40, 50, 50, 60, 70};
  int          deadTab [9] = '{1, 2, 3, 5, 5, 1, 0, 0, 0};

  // Short bit periods keep the run brief
  pgg_pattern_generator_gpio #(.BIT1_CYC(50), .BIT2_CYC(60), .BIT3_CYC(70))
    i_pgg_pattern_generator_gpio (.ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp),
    .multiPinIn(multiPinIn), .multiPin(multiPin), .auxPinIn(auxPinIn), .auxPin(auxPin),
    .hwEnable(hwEnable));
  pgg_led_model i_pgg_led_model (.multiPin(multiPin), .auxPin(auxPin), .multiExt(multiExt),
    .auxExt(auxExt), .multiPinIn(multiPinIn), .auxPinIn(auxPinIn));

  initial forever #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered and left at a falling edge; one idle cycle after each access
  // so back-to-back calls never assign req twice in one time step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '0;
    for (i = 0; i < 3 && !w && rsp.valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 3) begin
      error_cnt++;
      end_sim();
    end
    @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rsp.data, exp);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Entry from input mode restarts the pattern at bit 0
  task automatic runPat(input int k);
    int b;
    int len;
    len = 32 * (deadTab[k] + 1);
    acc(1'b1, `PGG_ADDR_MODE, 8'h03);
    acc(1'b1, `PGG_ADDR_MODE, modeTab[k]);
    // Idle cycle of acc already spent, so sample mid-bit
    waitn(perTab[k] / 2 - 1);
    for (b = 0; b < len + 4; b++) begin
      chk(multiPin.oe, (b % len) < 32 ? pat[b % 32] : 1'b0);
      waitn(perTab[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    waitn(8);
    rst = 1'b0;
    waitn(2);
    rdc(`PGG_ADDR_AUX, 8'hfc);
    for (int k = 0; k < 4; k++) rdc(8'(`PGG_ADDR_DATA0 + k), 8'h00);
    rdc(8'h55, 8'h00);
    auxExt = 1'b1;
    waitn(8);
    rdc(`PGG_ADDR_AUX, 8'hfe);
    acc(1'b1, `PGG_ADDR_AUX, 8'h03);
    waitn(1);
    chk(auxPin, 2'b11);
    rdc(`PGG_ADDR_AUX, 8'hff);
    acc(1'b1, `PGG_ADDR_AUX, 8'h01);
    waitn(1);
    chk(auxPin, 2'b01);
    $display("test aux pin done");
    acc(1'b1, `PGG_ADDR_MODE, 8'h05);
    waitn(1);
    chk(multiPin, 2'b11);
    acc(1'b1, `PGG_ADDR_MODE, 8'h03);
    waitn(8);
    rdc(`PGG_ADDR_MODE, 8'h07);
    multiExt = 1'b0;
    waitn(8);
    rdc(`PGG_ADDR_MODE, 8'h03);
    acc(1'b1, `PGG_ADDR_MODE, 8'h00);
    waitn(8);
    chk(hwEnable, 1'b0);
    multiExt = 1'b1;
    waitn(8);
    chk(hwEnable, 1'b1);
    $display("test multi pin done");
    for (int k = 0; k < 4; k++) acc(1'b1, 8'(`PGG_ADDR_DATA0 + k), pat[8 * k +: 8]);
    acc(1'b1, `PGG_ADDR_MODE, 8'h38);
    rdc(`PGG_ADDR_MODE, 8'h00);
    // Unlatched byte must not reach the pin
    acc(1'b1, `PGG_ADDR_DATA0, 8'hff);
    rdc(`PGG_ADDR_DATA0, 8'hff);
    for (int k = 0; k < 9; k++) runPat(k);
    $display("test pattern done");
    end_sim();
  end
endmodule
